// File: dbrd_map.svh
/*
  Offsets, field positions, reset values and timing counts of the dual
  baud-rate divider. Definitions only; included by the package, the divider and the top.
*/
`ifndef DBRD_MAP_SVH
`define DBRD_MAP_SVH

`define DBRD_CTRL_OFS        4'h0
`define DBRD_STATUS_OFS      4'h4
`define DBRD_RCV_DIV_OFS     4'h8
`define DBRD_XMT_DIV_OFS     4'hC

`define DBRD_CTRL_REF_SEL    0
`define DBRD_CTRL_RUN        1
`define DBRD_CTRL_RESET      2'h2

`define DBRD_ST_RCV_CODE_LO  0
`define DBRD_ST_XMT_CODE_LO  4
`define DBRD_ST_RCV_OUT      8
`define DBRD_ST_XMT_OUT      9

`define DBRD_CODE_RESET      4'h0
`define DBRD_DIV_MIN         15'h0002

`define DBRD_CLK_PERIOD_NS   100
`define DBRD_STROBE_MIN_NS   150
`define DBRD_STROBE_MIN_CYC  ((`DBRD_STROBE_MIN_NS + `DBRD_CLK_PERIOD_NS - 1) / `DBRD_CLK_PERIOD_NS)

`define DBRD_DIV_TABLE_DEFAULT {15'h0200, 15'h0180, 15'h0100, 15'h00C0, 15'h0080, 15'h0060, 15'h0040, 15'h0030, \
                                15'h0020, 15'h0018, 15'h0010, 15'h000C, 15'h0008, 15'h0006, 15'h0004, 15'h0003}

`endif

// File: dbrd_pkg.sv
/*
  Types and shared functions of the dual baud-rate divider.
  Assumes dbrd_map.svh is on the include path.
*/
`include "dbrd_map.svh"

package dbrd_pkg;

  typedef logic [14:0] dbrd_div_t;
  typedef logic [15:0][14:0] dbrd_div_table_t;

  typedef struct packed {
    logic      rate_out;
    logic [3:0] code;
    dbrd_div_t divisor;
  } dbrd_div_stat_t;

  typedef enum logic [1:0] {
    DBRD_BUS_IDLE = 2'b00,
    DBRD_BUS_ACK  = 2'b01
  } dbrd_bus_state_t;

  // Divide by one cannot toggle; anything below two runs as two
  function automatic dbrd_div_t dbrd_eff_div(input dbrd_div_t d);
    dbrd_eff_div = (d < `DBRD_DIV_MIN) ? `DBRD_DIV_MIN : d;
  endfunction

endpackage

// File: dbrd_sync3.sv
/*
  Three-flop synchroniser for a group of pins, one lane per bit.
  A lane takes a new value once its second and third flops agree.
  Assumes clk is the block clock and rst is synchronous, active high.
*/
`timescale 1ns/10ps
module dbrd_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] stable_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] agree;
  logic [W-1:0] stable_next;

  assign agree       = ~(s2_reg ^ s3_reg);
  assign stable_next = (agree & s3_reg) | (~agree & stable_reg);
  assign stable_out  = stable_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      stable_reg <= '0;
    end else begin
      s1_reg     <= async_in;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
    end
  end
endmodule

// File: dbrd_divider.sv
/*
  One rate divider: select register, lookup of the divisor and a 15-stage
  counter that turns reference ticks into a square rate output.
  Assumes ref_tick is a one-cycle pulse per reference period and load is
  the synchronised latch level on the same clock.
*/
`timescale 1ns/10ps
`include "dbrd_map.svh"
module dbrd_divider #(
  parameter dbrd_pkg::dbrd_div_table_t DIV_TABLE = `DBRD_DIV_TABLE_DEFAULT
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    run,
  input  wire logic                    ref_tick,
  input  wire logic                    load,
  input  wire logic [3:0]              code_in,
  output dbrd_pkg::dbrd_div_stat_t     stat
);
  import dbrd_pkg::*;

  logic [3:0] code_reg;
  logic [3:0] code_next;
  dbrd_div_t  cnt_reg;
  dbrd_div_t  cnt_next;
  logic       out_reg;
  logic       out_next;
  dbrd_div_t  eff;
  dbrd_div_t  half;
  logic       restart;
  logic       advance;
  logic       wrap;

  assign code_next = load ? code_in : code_reg;
  // Tied-high strobes reload every cycle; only a real change restarts
  assign restart   = load && (code_in != code_reg);
  assign eff       = dbrd_eff_div(DIV_TABLE[code_reg]);
  assign half      = eff >> 1;
  assign advance   = run && ref_tick && !restart;
  assign wrap      = (cnt_reg == eff - 15'h0001);
  assign cnt_next  = restart ? 15'h0000 : !advance ? cnt_reg : wrap ? 15'h0000 : cnt_reg + 15'h0001;
  // Output moves only with the count, so the low level after reset stands until the first tick or restart
  assign out_next  = (advance || restart) ? (cnt_next < half) : out_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      code_reg <= `DBRD_CODE_RESET;
      cnt_reg  <= 15'h0000;
      out_reg  <= 1'b0;
    end else begin
      code_reg <= code_next;
      cnt_reg  <= cnt_next;
      out_reg  <= out_next;
    end
  end

  assign stat.rate_out = out_reg;
  assign stat.code     = code_reg;
  assign stat.divisor  = eff;

  default clocking dclk @(posedge clk); endclocking
  default disable iff (rst);

  chk_code_load: assert property (load |=> code_reg == $past(code_in))
    else $error("select register missed a load");
  chk_restart_count: assert property (restart |=> cnt_reg == 15'h0000 && out_reg)
    else $error("divider did not restart on new code");
  chk_cnt_range: assert property (cnt_reg < eff)
    else $error("divider count beyond divisor");
  chk_tick_step: assert property (advance && !wrap |=> cnt_reg == $past(cnt_reg) + 15'h0001)
    else $error("divider count did not step on tick");
  chk_hold_idle: assert property (!ref_tick && !load |=> $stable(cnt_reg) && $stable(out_reg))
    else $error("divider moved without a tick");
endmodule

// File: dbrd_top.sv
/*
  Dual baud-rate divider: one reference clock feeds independent receive and
  transmit dividers whose codes are latched from pins; an Avalon-MM slave
  gives software reference selection, run control and state readback.
  Assumes a 10 MHz clk, a reference well below clk/4 and pins asynchronous.
*/
`timescale 1ns/10ps
`include "dbrd_map.svh"
module dbrd_top #(
  parameter dbrd_pkg::dbrd_div_table_t DIV_TABLE = `DBRD_DIV_TABLE_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ref_clock_in_a,
  input  wire logic        ref_clock_in_b,
  input  wire logic [3:0]  rcv_select_code,
  input  wire logic        rcv_select_latch_pulse,
  input  wire logic [3:0]  xmt_select_code,
  input  wire logic        xmt_select_latch_pulse,
  output logic             rcv_rate_out,
  output logic             xmt_rate_out
);
  import dbrd_pkg::*;

  localparam int STROBE_MIN_CYC = `DBRD_STROBE_MIN_CYC;

  // Pin synchronisation
  logic [11:0] pins_async;
  logic [11:0] pins_st;
  logic        ref_a_st;
  logic        ref_b_st;
  logic        rcv_load_st;
  logic [3:0]  rcv_code_st;
  logic        xmt_load_st;
  logic [3:0]  xmt_code_st;

  assign pins_async = {ref_clock_in_a, ref_clock_in_b,
                       rcv_select_latch_pulse, rcv_select_code,
                       xmt_select_latch_pulse, xmt_select_code};

  // Strobes shorter than two clock periods may be missed by the filter,
  // which is the price of rejecting single-sample glitches
  dbrd_sync3 #(
    .W (12)
  ) u_pin_sync (
    .clk        (clk),
    .rst        (rst),
    .async_in   (pins_async),
    .stable_out (pins_st)
  );

  assign ref_a_st    = pins_st[11];
  assign ref_b_st    = pins_st[10];
  assign rcv_load_st = pins_st[9];
  assign rcv_code_st = pins_st[8:5];
  assign xmt_load_st = pins_st[4];
  assign xmt_code_st = pins_st[3:0];

  // Control register
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic       ref_sel;
  logic       run;

  assign ref_sel = ctrl_reg[`DBRD_CTRL_REF_SEL];
  assign run     = ctrl_reg[`DBRD_CTRL_RUN];

  // Reference edge detection; input b is the opposite polarity of input a
  logic ref_level;
  logic ref_prev_reg;
  logic ref_tick;

  assign ref_level = ref_sel ? ~ref_b_st : ref_a_st;
  assign ref_tick  = ref_level & ~ref_prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_level;
    end
  end

  // Both dividers share the reference, the table and the run bit, nothing else
  dbrd_div_stat_t rcv_stat;
  dbrd_div_stat_t xmt_stat;

  dbrd_divider #(
    .DIV_TABLE (DIV_TABLE)
  ) u_rcv_div (
    .clk      (clk),
    .rst      (rst),
    .run      (run),
    .ref_tick (ref_tick),
    .load     (rcv_load_st),
    .code_in  (rcv_code_st),
    .stat     (rcv_stat)
  );

  dbrd_divider #(
    .DIV_TABLE (DIV_TABLE)
  ) u_xmt_div (
    .clk      (clk),
    .rst      (rst),
    .run      (run),
    .ref_tick (ref_tick),
    .load     (xmt_load_st),
    .code_in  (xmt_code_st),
    .stat     (xmt_stat)
  );

  assign rcv_rate_out = rcv_stat.rate_out;
  assign xmt_rate_out = xmt_stat.rate_out;

  // Avalon-MM slave: every access waits exactly one cycle
  dbrd_bus_state_t bus_state_reg;
  dbrd_bus_state_t bus_state_next;
  logic            req;
  logic            wr_fire;
  logic            hit_ctrl;
  logic            hit_status;
  logic            hit_rcv_div;
  logic            hit_xmt_div;
  logic [31:0]     rd_mux;
  logic [31:0]     status_word;
  logic [31:0]     readdata_reg;
  logic [31:0]     readdata_next;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req && (bus_state_reg == DBRD_BUS_IDLE);
  assign wr_fire         = avs_write && !avs_waitrequest;

  assign hit_ctrl    = (avs_address == `DBRD_CTRL_OFS);
  assign hit_status  = (avs_address == `DBRD_STATUS_OFS);
  assign hit_rcv_div = (avs_address == `DBRD_RCV_DIV_OFS);
  assign hit_xmt_div = (avs_address == `DBRD_XMT_DIV_OFS);

  assign status_word = {22'h000000, xmt_stat.rate_out, rcv_stat.rate_out,
                        xmt_stat.code, rcv_stat.code};

  always_comb begin
    if (hit_ctrl) begin
      rd_mux = {30'h00000000, ctrl_reg};
    end else if (hit_status) begin
      rd_mux = status_word;
    end else if (hit_rcv_div) begin
      rd_mux = {17'h00000, rcv_stat.divisor};
    end else if (hit_xmt_div) begin
      rd_mux = {17'h00000, xmt_stat.divisor};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  always_comb begin
    case (bus_state_reg)
      DBRD_BUS_IDLE: bus_state_next = req ? DBRD_BUS_ACK : DBRD_BUS_IDLE;
      DBRD_BUS_ACK:  bus_state_next = DBRD_BUS_IDLE;
      default:       bus_state_next = DBRD_BUS_IDLE;
    endcase
  end

  assign readdata_next = (avs_read && bus_state_reg == DBRD_BUS_IDLE) ? rd_mux : readdata_reg;
  assign ctrl_next     = (wr_fire && hit_ctrl && avs_byteenable[0]) ? avs_writedata[1:0] : ctrl_reg;
  assign avs_readdata  = readdata_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_state_reg <= DBRD_BUS_IDLE;
      readdata_reg  <= 32'h00000000;
      ctrl_reg      <= `DBRD_CTRL_RESET;
    end else begin
      bus_state_reg <= bus_state_next;
      readdata_reg  <= readdata_next;
      ctrl_reg      <= ctrl_next;
    end
  end

  // Checks
  logic [2:0] rcv_load_len_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      rcv_load_len_reg <= 3'h0;
    end else if (rcv_load_st) begin
      rcv_load_len_reg <= (rcv_load_len_reg == 3'h7) ? 3'h7 : rcv_load_len_reg + 3'h1;
    end else begin
      rcv_load_len_reg <= 3'h0;
    end
  end

  default clocking dclk @(posedge clk); endclocking
  default disable iff (rst);

  chk_bus_one_wait: assert property (req && bus_state_reg == DBRD_BUS_IDLE |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  chk_ctrl_write: assert property (wr_fire && hit_ctrl && avs_byteenable[0] |=> ctrl_reg == $past(avs_writedata[1:0]))
    else $error("control write lost");
  chk_read_status: assert property (avs_read && hit_status && avs_waitrequest |=>
                                    avs_readdata[7:0] == {$past(xmt_stat.code), $past(rcv_stat.code)})
    else $error("status read shows wrong codes");
  chk_unmapped_zero: assert property (avs_read && avs_waitrequest && !(hit_ctrl || hit_status || hit_rcv_div ||
                                      hit_xmt_div) |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_rcv_indep: assert property (rcv_load_st && !xmt_load_st |=> $stable(xmt_stat.code))
    else $error("receive load disturbed transmit code");
  chk_xmt_indep: assert property (xmt_load_st && !rcv_load_st |=> $stable(rcv_stat.code))
    else $error("transmit load disturbed receive code");
  chk_xmt_load: assert property (xmt_load_st |=> xmt_stat.code == $past(xmt_code_st))
    else $error("transmit select register missed a load");
  chk_run_hold: assert property (!run |=> $stable(rcv_rate_out) || $past(rcv_load_st))
    else $error("receive output moved while stopped");
  chk_div_table: assert property (rcv_stat.divisor == dbrd_eff_div(DIV_TABLE[rcv_stat.code]))
    else $error("receive divisor not from table");

  // Select registers hold between loads and restart high on a new code
  chk_rcv_load: assert property (
    rcv_load_st |=> rcv_stat.code == $past(rcv_code_st))
    else $error("receive select register missed a load");
  chk_rcv_code_kept: assert property (
    !rcv_load_st |=> $stable(rcv_stat.code))
    else $error("receive code changed without a load");
  chk_rcv_restart_high: assert property (
    rcv_load_st && rcv_code_st != rcv_stat.code |=> rcv_rate_out)
    else $error("receive output not high after restart");
  chk_xmt_restart_high: assert property (
    xmt_load_st && xmt_code_st != xmt_stat.code |=> xmt_rate_out)
    else $error("transmit output not high after restart");

  // Outputs move only on a tick or a restart, so a cascaded divider sees clean edges
  chk_tick_single: assert property (
    ref_tick |=> !ref_tick)
    else $error("reference tick longer than one cycle");
  chk_rcv_out_quiet: assert property (
    !ref_tick && !rcv_load_st |=> $stable(rcv_rate_out))
    else $error("receive output moved without a tick");
  chk_xmt_out_quiet: assert property (
    !ref_tick && !xmt_load_st |=> $stable(xmt_rate_out))
    else $error("transmit output moved without a tick");
  chk_xmt_run_hold: assert property (
    !run |=> $stable(xmt_rate_out) || $past(xmt_load_st))
    else $error("transmit output moved while stopped");

  // One table feeds both dividers
  chk_rcv_div_floor: assert property (
    rcv_stat.divisor >= `DBRD_DIV_MIN)
    else $error("receive divisor below minimum");
  chk_xmt_div_floor: assert property (
    xmt_stat.divisor >= `DBRD_DIV_MIN)
    else $error("transmit divisor below minimum");
  chk_shared_table: assert property (
    rcv_stat.code == xmt_stat.code |-> rcv_stat.divisor == xmt_stat.divisor)
    else $error("equal codes give different divisors");

  // Register bus side effects
  chk_ctrl_kept: assert property (
    !wr_fire |=> $stable(ctrl_reg))
    else $error("control changed without a write");
  chk_readdata_kept: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  chk_read_ctrl: assert property (
    avs_read && hit_ctrl && avs_waitrequest |=> avs_readdata == {30'h0, $past(ctrl_reg)})
    else $error("control read wrong");
  chk_read_rcv_div: assert property (
    avs_read && hit_rcv_div && avs_waitrequest |=> avs_readdata == {17'h00000, $past(rcv_stat.divisor)})
    else $error("receive divisor read wrong");
  chk_read_xmt_div: assert property (
    avs_read && hit_xmt_div && avs_waitrequest |=> avs_readdata == {17'h00000, $past(xmt_stat.divisor)})
    else $error("transmit divisor read wrong");
  chk_read_rates: assert property (
    avs_read && hit_status && avs_waitrequest |=> avs_readdata[9:8] == {$past(xmt_rate_out), $past(rcv_rate_out)})
    else $error("status read shows wrong rate levels");

  cov_rcv_restart: cover property (rcv_load_st ##1 $changed(rcv_stat.code));
  cov_xmt_toggle: cover property ($rose(xmt_rate_out) ##[1:1000] $fell(xmt_rate_out));
  cov_strobe_min: cover property (rcv_load_len_reg == 3'(STROBE_MIN_CYC) ##1 !rcv_load_st);
  cov_ctrl_write: cover property (wr_fire && hit_ctrl);
  cov_ref_b_tick: cover property (ref_sel && ref_tick);
endmodule

// File: dbrd_rate_sink.sv
/*
  Far-side clock sink: a serial unit clocked by one rate output.
  Assumes the rate output is a level sampled on the block clock.
*/
`timescale 1ns/10ps
module dbrd_rate_sink (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rate,
  output logic      [15:0] period,
  output logic      [15:0] high_time,
  output logic      [15:0] rises
);
  logic        rate_q;
  logic [15:0] cnt;
  // Every rising edge clocks the serial unit, so one clean edge per period is needed
  always @(posedge clk) begin
    rate_q <= rate;
    cnt <= (rate && !rate_q) ? 16'h0001 : cnt + 16'h0001;
    if (rst) begin
      rises <= 16'h0000;
    end else if (rate && !rate_q) begin
      period <= cnt;
      rises <= rises + 16'h0001;
    end
    if (!rate && rate_q) begin
      high_time <= cnt;
    end
  end
endmodule

// File: testbench.sv
/*
  Testbench: select pins, two reference clocks and an Avalon master.
  Assumes the design files and the rate sink are compiled before it.
*/
`timescale 1ns/10ps
module testbench;
  import dbrd_pkg::*;
  // Own table: odd divisors, one below the minimum, one at the counter limit
  localparam dbrd_div_table_t TBL = {15'h7FFF, 15'h001F, 15'h001D, 15'h001B, 15'h0019, 15'h0017, 15'h0015,
    15'h0013, 15'h0011, 15'h000F, 15'h000D, 15'h000B, 15'h0009, 15'h0007, 15'h0005, 15'h0001};
  logic        clk, rst, avs_read, avs_write, avs_waitrequest, ref_clock_in_a, ref_clock_in_b;
  logic [3:0]  avs_address, avs_byteenable, rcv_select_code, xmt_select_code;
  logic [31:0] avs_writedata, avs_readdata;
  logic        rcv_select_latch_pulse, xmt_select_latch_pulse, rcv_rate_out, xmt_rate_out;
  logic [15:0] rp, rh, rr, xp, xh, xr;
  logic [2:0]  ca;
  logic [3:0]  cb;
  int          num_errors, comparisons;

  dbrd_top #(.DIV_TABLE(TBL)) dbrd_top_inst (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ref_clock_in_a, .ref_clock_in_b, .rcv_select_code,
    .rcv_select_latch_pulse, .xmt_select_code, .xmt_select_latch_pulse, .rcv_rate_out, .xmt_rate_out);
  dbrd_rate_sink rcv_sink_inst (.clk, .rst, .rate(rcv_rate_out), .period(rp), .high_time(rh), .rises(rr));
  dbrd_rate_sink xmt_sink_inst (.clk, .rst, .rate(xmt_rate_out), .period(xp), .high_time(xh), .rises(xr));

  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end

  // Reference a: period 6 clocks; reference b: period 10 clocks
  always @(posedge clk) begin
    ca <= (ca == 3'h2) ? 3'h0 : ca + 3'h1;
    cb <= (cb == 4'h4) ? 4'h0 : cb + 4'h1;
    if (ca == 3'h2) ref_clock_in_a <= !ref_clock_in_a;
    if (cb == 4'h4) ref_clock_in_b <= !ref_clock_in_b;
  end

  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    num_errors++;
    $display("[ERR] %s expected done seen timeout", nm);
    test_done;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) hang("bus");
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, e, q & m);
  endtask

  task automatic per(input logic x, input int n, input int f);
    logic [15:0] r0;
    int k;
    r0 = x ? xr : rr;
    k = 0;
    while (16'((x ? xr : rr) - r0) < 16'h0003 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) hang("rise wait");
    chk("period", f * n, x ? xp : rp);
    chk("high time", f * (n / 2), x ? xh : rh);
  endtask

  function automatic logic [31:0] ediv(input int i);
    ediv = (i == 0) ? 32'h2 : (i == 15) ? 32'h7FFF : 2 * i + 3;
  endfunction

  task automatic t_reset;
    logic [31:0] q;
    rd(4'h0, 32'hFFFFFFFF, 32'h2, "ctrl reset");
    rd(4'h4, 32'hFF, 32'h0, "codes reset");
    rd(4'h8, 32'h7FFF, 32'h2, "rcv divisor floor");
    rd(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped read");
    bus(1'b1, 4'h4, 32'hFFFFFFFF, 4'hF, q);
    rd(4'h4, 32'hFF, 32'h0, "status write ignored");
  endtask

  task automatic t_sweep;
    rcv_select_latch_pulse <= 1'b1;
    xmt_select_latch_pulse <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rcv_select_code <= i[3:0];
      xmt_select_code <= 4'hF - i[3:0];
      repeat (10) @(posedge clk);
      rd(4'h8, 32'h7FFF, ediv(i), "rcv divisor");
      rd(4'hC, 32'h7FFF, ediv(15 - i), "xmt divisor");
      rd(4'h4, 32'hFF, {24'h0, 4'hF - i[3:0], i[3:0]}, "codes");
      if (i < 15) per(1'b0, ediv(i), 6);
      if (i > 0) per(1'b1, ediv(15 - i), 6);
    end
  endtask

  task automatic t_strobe;
    rcv_select_latch_pulse <= 1'b0;
    xmt_select_latch_pulse <= 1'b0;
    rcv_select_code <= 4'h3;
    xmt_select_code <= 4'h6;
    repeat (6) @(posedge clk);
    rcv_select_latch_pulse <= 1'b1;
    repeat (2) @(posedge clk);
    rcv_select_latch_pulse <= 1'b0;
    repeat (6) @(posedge clk);
    rcv_select_code <= 4'h9;
    repeat (8) @(posedge clk);
    rd(4'h4, 32'hFF, 32'h03, "codes after rcv load");
    per(1'b0, 9, 6);
    xmt_select_latch_pulse <= 1'b1;
    repeat (2) @(posedge clk);
    xmt_select_latch_pulse <= 1'b0;
    repeat (8) @(posedge clk);
    rd(4'h4, 32'hFF, 32'h63, "codes after xmt load");
    per(1'b1, 15, 6);
  endtask

  task automatic t_ctrl;
    logic [31:0] q;
    logic [15:0] r0;
    bus(1'b1, 4'h0, 32'h3, 4'hF, q);
    rd(4'h0, 32'hFFFFFFFF, 32'h3, "ctrl ref b");
    per(1'b0, 9, 10);
    bus(1'b1, 4'h0, 32'h2, 4'h0, q);
    rd(4'h0, 32'hFFFFFFFF, 32'h3, "ctrl no byte enable");
    bus(1'b1, 4'h0, 32'h1, 4'hF, q);
    // A tick taken in the write's last cycle still reaches the sink a cycle later
    repeat (4) @(posedge clk);
    r0 = rr;
    repeat (300) @(posedge clk);
    chk("rises while stopped", r0, rr);
    rd(4'h4, 32'h300, {22'h0, xmt_rate_out, rcv_rate_out, 8'h00}, "rate bits");
    bus(1'b1, 4'h0, 32'h2, 4'hF, q);
    per(1'b1, 15, 6);
  endtask

  initial begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {ref_clock_in_a, ref_clock_in_b, ca, cb} = '0;
    {rcv_select_code, xmt_select_code, rcv_select_latch_pulse, xmt_select_latch_pulse} = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_sweep;
    t_strobe;
    t_ctrl;
    test_done;
  end
endmodule
